// ### ext_osc_ctrl.sv
/*
  External oscillator control register and mode decode, reached over the
  core's special-function register port at its documented address.
  Assumes the analog amplifier, crossbar and clock mux sit outside; the
  oscillator output and amplitude detector arrive as asynchronous pins.
*/
// Notes on behaviour
// R01 - Bit 7 is read-only valid flag: 0 unused or unstable, 1 running stable
// R02 - Valid flag meaningful only in crystal modes 11x
// R03 - Mode 00x switches the external oscillator circuit off
// R04 - Mode 010 is CMOS clock, 011 is CMOS clock divided by two
// R05 - Mode 111 is crystal with a divide-by-two stage
// R06 - Mode 100 is RC, 101 capacitor, 110 crystal undivided
// R07 - Bit 3 reads zero and ignores writes
// R08 - Crystal mode: software sets drive field to crystal frequency band
// R09 - RC mode: software sets drive field to RC frequency band
// R10 - Capacitor mode: software picks drive code by needed K factor
// R11 - Software drives both crystal pins low, then makes them analog inputs
// R12 - Software waits at least 1 ms before polling valid flag
// R13 - Software enables missing clock detector before switching to external clock
// R14 - Software may drop drive to 000 once a 32.768 kHz crystal settles
// R15 - Crystal mode uses P0.2 and P0.3; other active modes only P0.3
// R16 - Reset clears every field: oscillator off, valid flag zero
`timescale 1ns/1ps
`default_nettype none
`include "ext_osc_defs.svh"

module ext_osc_ctrl
  import ext_osc_pkg::*;
(
  input wire logic clk_i,           // System clock, 200 MHz
  input wire logic resetn_i,        // Async reset, active low
  input wire logic [7:0] sfr_addr_i, // Register address
  input wire logic sfr_wr_i,        // Write strobe
  input wire logic sfr_rd_i,        // Read strobe
  input wire logic [7:0] sfr_wdata_i, // Write data
  output logic [7:0] sfr_rdata_o,   // Read data, one cycle after strobe
  input wire logic osc_clk_i,       // Oscillator output, asynchronous
  input wire logic amp_ok_i,        // Amplitude detector, asynchronous
  output logic osc_en_o,            // Drive circuit enabled
  output logic xtal_amp_en_o,       // Crystal amplifier in use
  output logic [2:0] external_osc_drive_select_o, // Drive band to analog
  output logic crystal_input_pin_use_o,  // P0.2 claimed
  output logic crystal_output_pin_use_o, // P0.3 claimed
  output logic crystal_valid_flag_o, // Valid flag copy
  output logic ext_tick_o           // One pulse per (divided) osc period
);

  osc_mode_e external_osc_mode_select_r;
  logic [2:0] drive_r;
  logic valid_r;
  logic osc_lvl;
  logic amp_lvl;
  logic osc_prev_r;
  logic half_r;
  logic hit;
  logic osc_on;
  logic is_xtal;
  logic use_div2;
  logic osc_rise;
  osc_ctrl_s rd_img;

  assign hit = (sfr_addr_i == `EXT_OSC_CTRL_ADDR);

  // Both pins are foreign to this clock, so each gets the filtered chain
  pin_sync u_osc_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(osc_clk_i),
    .level_o(osc_lvl)
  );

  pin_sync u_amp_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(amp_ok_i),
    .level_o(amp_lvl)
  );

  // Mode decode; every code is legal so no default
  always_comb begin
    osc_on = 1'b0;
    is_xtal = 1'b0;
    use_div2 = 1'b0;
    unique case (external_osc_mode_select_r)
      MODE_OFF_A, MODE_OFF_B: osc_on = 1'b0; // R03
      MODE_CMOS: osc_on = 1'b1; // R04
      MODE_CMOS_DIV2: begin // R04
        osc_on = 1'b1;
        use_div2 = 1'b1;
      end
      MODE_RC, MODE_CAP: osc_on = 1'b1; // R06
      MODE_XTAL: begin // R06
        osc_on = 1'b1;
        is_xtal = 1'b1;
      end
      MODE_XTAL_DIV2: begin // R05
        osc_on = 1'b1;
        is_xtal = 1'b1;
        use_div2 = 1'b1;
      end
    endcase
  end

  // Control fields; bits 7 and 3 of the write data are dropped
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      external_osc_mode_select_r <= osc_mode_e'(`EXT_OSC_MODE_RESET); // R16
      drive_r <= `EXT_OSC_DRIVE_RESET; // R16
    end else if (sfr_wr_i && hit) begin
      external_osc_mode_select_r <=
        osc_mode_e'(sfr_wdata_i[`EXT_OSC_MODE_HI:`EXT_OSC_MODE_LO]);
      drive_r <= sfr_wdata_i[`EXT_OSC_DRIVE_HI:`EXT_OSC_DRIVE_LO];
    end
  end

  // Valid only follows the detector in crystal modes; forced low elsewhere
  // so a stale amplitude reading never advertises a stopped crystal
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_r <= 1'b0; // R16
    end else begin
      valid_r <= is_xtal && amp_lvl; // R01 R02
    end
  end

  // Read port: registered, unmapped addresses answer zero
  always_comb begin
    rd_img.valid = valid_r; // R01
    rd_img.mode = external_osc_mode_select_r;
    rd_img.unused = 1'b0; // R07
    rd_img.drive = drive_r;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sfr_rdata_o <= `EXT_OSC_CTRL_RESET;
    end else if (sfr_rd_i && hit) begin
      sfr_rdata_o <= rd_img;
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // Rising edge of the synchronised oscillator; only usable while the
  // oscillator is well below half the system clock
  assign osc_rise = osc_lvl && !osc_prev_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_lvl;
    end
  end

  // Divide-by-two phase, held clear while undivided or off
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      half_r <= 1'b0;
    end else if (!(osc_on && use_div2)) begin
      half_r <= 1'b0;
    end else if (osc_rise) begin
      half_r <= !half_r; // R04 R05
    end
  end

  // Tick pulse: every rise, or every second rise in divided modes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_tick_o <= 1'b0;
    end else begin
      ext_tick_o <= osc_on && osc_rise && (!use_div2 || half_r); // R03 R04 R05
    end
  end

  // Analog and pin controls, registered so outputs are glitch free
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_en_o <= 1'b0;
      xtal_amp_en_o <= 1'b0;
      external_osc_drive_select_o <= `EXT_OSC_DRIVE_RESET;
      crystal_input_pin_use_o <= 1'b0;
      crystal_output_pin_use_o <= 1'b0;
      crystal_valid_flag_o <= 1'b0;
    end else begin
      osc_en_o <= osc_on; // R03
      xtal_amp_en_o <= is_xtal;
      external_osc_drive_select_o <= drive_r;
      crystal_input_pin_use_o <= is_xtal; // R15
      crystal_output_pin_use_o <= osc_on; // R15
      crystal_valid_flag_o <= valid_r;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Read data carries the valid flag in bit 7 one cycle after the strobe
  valid_read_a: assert property ((sfr_rd_i && hit) |=> // R01
    (sfr_rdata_o[`EXT_OSC_VALID_BIT] == $past(valid_r)))
    else $error("valid flag not returned on read");

  valid_xtal_a: assert property (valid_r |-> $past(is_xtal) && $past(amp_lvl)) // R02
    else $error("valid flag set outside crystal mode");

  off_mode_a: assert property ((external_osc_mode_select_r[2:1] == 2'b00) // R03
    |=> !osc_en_o && !ext_tick_o)
    else $error("oscillator active while mode is off");

  cmos_pass_a: assert property ((external_osc_mode_select_r == MODE_CMOS // R04
    && $stable(external_osc_mode_select_r) && osc_rise) |=> ext_tick_o)
    else $error("CMOS tick missed");

  div_two_a: assert property ((use_div2 && osc_rise && !half_r // R05
    && $stable(external_osc_mode_select_r)) |=> !ext_tick_o)
    else $error("divided mode ticked on odd edge");

  xtal_only_a: assert property ((external_osc_mode_select_r inside // R06
    {MODE_RC, MODE_CAP}) |=> osc_en_o && !xtal_amp_en_o)
    else $error("RC or capacitor mode decoded wrong");

  bit3_zero_a: assert property ((sfr_rd_i && hit) |=> // R07
    !sfr_rdata_o[`EXT_OSC_UNUSED_BIT])
    else $error("unused bit reads nonzero");

  pin_claim_a: assert property (crystal_input_pin_use_o |-> // R15
    crystal_output_pin_use_o)
    else $error("P0.2 claimed without P0.3");

  write_take_a: assert property ((sfr_wr_i && hit) |=> // R08 R09 R10
    (drive_r == $past(sfr_wdata_i[2:0])))
    else $error("drive field write lost");

  cmos_run_c: cover property (external_osc_mode_select_r == MODE_CMOS_DIV2
    ##1 ext_tick_o);
  xtal_valid_c: cover property (is_xtal ##1 valid_r);
  rc_run_c: cover property (external_osc_mode_select_r == MODE_RC && ext_tick_o);

endmodule // ext_osc_ctrl

`default_nettype wire

// ### ext_osc_defs.svh
/*
  Offsets, field positions and reset values of the external oscillator
  control register. Definitions only; included by its bare name.
*/
`ifndef EXT_OSC_DEFS_SVH
`define EXT_OSC_DEFS_SVH

`define EXT_OSC_CTRL_ADDR 8'hB1
`define EXT_OSC_CTRL_RESET 8'h00
`define EXT_OSC_VALID_BIT 7
`define EXT_OSC_MODE_HI 6
`define EXT_OSC_MODE_LO 4
`define EXT_OSC_UNUSED_BIT 3
`define EXT_OSC_DRIVE_HI 2
`define EXT_OSC_DRIVE_LO 0
`define EXT_OSC_MODE_RESET 3'h0
`define EXT_OSC_DRIVE_RESET 3'h0

`endif

// ### ext_osc_pkg.sv
/*
  Types of the external oscillator control block: the mode enumeration
  and the packed layout of the control register.
  Assumes the offsets and field positions come from ext_osc_defs.svh.
*/
`default_nettype none

package ext_osc_pkg;

  // Mode selector values in code order 000 to 111
  typedef enum logic [2:0] {
    MODE_OFF_A,
    MODE_OFF_B,
    MODE_CMOS,
    MODE_CMOS_DIV2,
    MODE_RC,
    MODE_CAP,
    MODE_XTAL,
    MODE_XTAL_DIV2
  } osc_mode_e;

  // Register image as software sees it
  typedef struct packed {
    logic valid;
    osc_mode_e mode;
    logic unused;
    logic [2:0] drive;
  } osc_ctrl_s;

endpackage

`default_nettype wire

// ### pin_sync.sv
/*
  Three-stage synchroniser for an input from outside the clock domain.
  The output follows only once the second and third stages agree.
  Assumes one system clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire logic clk_i,     // System clock
  input wire logic resetn_i,  // Async reset, active low
  input wire logic async_i,   // Raw pin level
  output logic level_o        // Filtered synchronous level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a change only when two settled stages agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_o <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_o <= s3_r;
    end
  end

endmodule // pin_sync

`default_nettype wire

// ### osc_source.sv
/*
  Far-side source model: free-running clock plus amplitude detector.
  Assumes the crystal amplifier enable comes from the control block.
*/
`timescale 1ns/1ps
`default_nettype none

module osc_source #(
  parameter int HALF_NS = 20,    // Half period of the source
  parameter int SETTLE_NS = 2000 // Amplitude settle, shortened
) (
  input wire logic xtal_i, // Crystal amplifier in use
  output logic osc_o,      // Oscillator output
  output logic amp_ok_o    // Amplitude good
);
  // External clock runs free, unrelated to the system clock
  initial begin
    osc_o = 1'b0;
    forever #(HALF_NS) osc_o = ~osc_o;
  end
  // Amplitude needs time after the amplifier starts; a drop restarts it,
  // so a quick off and on never inherits the old settle time
  initial begin
    amp_ok_o = 1'b0;
    forever begin
      @(xtal_i);
      amp_ok_o = 1'b0;
      for (int t = 0; t < SETTLE_NS && xtal_i === 1'b1; t++) #1;
      amp_ok_o = (xtal_i === 1'b1);
    end
  end
endmodule // osc_source

`default_nettype wire

// ### external_oscillator_control_bench.sv
/*
  Self-checking bench for the oscillator control register.
  Assumes osc_source on the pins and a 200 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module external_oscillator_control_bench;
  import ext_osc_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic osc_clk, amp_ok, osc_en, xtal_en, pin_in, pin_out, valid, tick;
  logic [2:0] drive;
  logic [15:0] lfsr = 16'hC0F8;
  logic [7:0] ua;
  logic [2:0] last_drive;
  int num_errors = 0;
  int samples_checked = 0;
  int ticks = 0;
  int exp_t;

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (tick === 1'b1) ticks++;

  ext_osc_ctrl ext_osc_ctrl_i (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .osc_clk_i(osc_clk), .amp_ok_i(amp_ok), .osc_en_o(osc_en), .xtal_amp_en_o(xtal_en),
    .external_osc_drive_select_o(drive), .crystal_input_pin_use_o(pin_in),
    .crystal_output_pin_use_o(pin_out), .crystal_valid_flag_o(valid), .ext_tick_o(tick));
  osc_source osc_source_i (.xtal_i(xtal_en), .osc_o(osc_clk), .amp_ok_o(amp_ok));

  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Expected {osc_en, xtal, pin P0.2, pin P0.3} from the mode code
  function automatic logic [3:0] pins(input logic [2:0] m);
    return {m[2:1] != 2'b00, m[2:1] == 2'b11, m[2:1] == 2'b11, m[2:1] != 2'b00};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One strobe cycle; read data is sampled in the cycle after the strobe
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 3900 cycles
  initial begin
    #100us;
    num_errors++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    check({3'h0, valid, osc_en, xtal_en, pin_in, pin_out}, 8'h00);
    access(8'hB1, 1'b0, 8'h00);
    check(rdata, 8'h00);
    // Every mode, random drive, junk in bits 7 and 3
    for (int m = 0; m < 8; m++) begin
      lfsr = nxt(lfsr);
      access(8'hB1, 1'b1, {lfsr[7], m[2:0], lfsr[3:0]});
      access(8'hB1, 1'b0, 8'h00);
      check(rdata, {1'b0, m[2:0], 1'b0, lfsr[2:0]});
      check({4'h0, osc_en, xtal_en, pin_in, pin_out}, {4'h0, pins(m[2:0])});
      check({5'h00, drive}, {5'h00, lfsr[2:0]});
    end
    // Unmapped address: write ignored, read gives zero
    last_drive = lfsr[2:0];
    lfsr = nxt(lfsr);
    ua = (lfsr[7:0] == 8'hB1) ? 8'h00 : lfsr[7:0];
    access(ua, 1'b1, 8'h25);
    access(ua, 1'b0, 8'h00);
    check(rdata, 8'h00);
    access(8'hB1, 1'b0, 8'h00);
    check(rdata, {1'b0, 3'h7, 1'b0, last_drive});
    // Crystal start-up: off, enable, wait, poll for the valid flag
    access(8'hB1, 1'b1, 8'h00);
    repeat (10) @(posedge clk_i);
    // Both pins back with the crossbar so firmware can hold them low
    check({6'h00, pin_in, pin_out}, 8'h00);
    access(8'hB1, 1'b1, 8'h67);
    repeat (100) @(posedge clk_i);
    for (int i = 0; i < 1000 && rdata[7] !== 1'b1; i++) access(8'hB1, 1'b0, 8'h00);
    check(rdata, 8'hE7);
    check({7'h00, valid}, 8'h01);
    access(8'hB1, 1'b1, 8'h60);
    access(8'hB1, 1'b0, 8'h00);
    check(rdata, 8'hE0);
    access(8'hB1, 1'b1, 8'h40);
    access(8'hB1, 1'b0, 8'h00);
    check(rdata, 8'h40);
    // RC band for 100 kHz, then capacitor mode with K factor 22
    access(8'hB1, 1'b1, 8'h42);
    access(8'hB1, 1'b0, 8'h00);
    check(rdata, 8'h42);
    access(8'hB1, 1'b1, 8'h53);
    access(8'hB1, 1'b0, 8'h00);
    check(rdata, 8'h53);
    check({5'h00, drive}, 8'h03);
    // Tick rate per mode: 8-cycle source period over 400 cycles
    for (int m = 0; m < 8; m++) begin
      access(8'hB1, 1'b1, {1'b0, m[2:0], 4'h0});
      repeat (20) @(posedge clk_i);
      #1;
      ticks = 0;
      repeat (400) @(posedge clk_i);
      #1;
      exp_t = (m < 2) ? 0 : ((m == 3 || m == 7) ? 25 : 50);
      check({7'h00, (exp_t == 0) ? ticks == 0 : (ticks >= exp_t - 1 && ticks <= exp_t + 1)},
        8'h01);
    end
    // Reset in mid-run with the crystal up clears every field again
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    check({2'h0, tick, valid, osc_en, xtal_en, pin_in, pin_out}, 8'h00);
    access(8'hB1, 1'b0, 8'h00);
    check(rdata, 8'h00);
    final_report();
  end
endmodule // external_oscillator_control_bench

`default_nettype wire
